// ===== design/mpc_ctl.sv
// Purpose: controller end, issues half-rate writes and reads over the link
// Assumes: one command at a time; write data queued ahead in the FIFO
// Notes:   each command is followed by at least two idle controller cycles
// Notes on behaviour
// - PHY reports write latency after calibration
// - data words align to controller cycles
// - slice zero first, slice one next beat
// - write byte lanes leave lowest first
// - two idle cycles after a read, four after a write
// - strobe burst leads write valid one beat
// - write valid waits write latency after select
// - read enable leads select; both slices high
// - read enable held for whole burst
// - read valid after read latency; capture on it
// - lower half goes to memory first
// - memory takes commands only under select
// - address identical in both slices
// - width ratio two at half rate
`timescale 1ns/1ns
`default_nettype none
module mpc_fifo
  import mpc_pkg::*;
#(
  parameter int W     = AFI_DQ_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_rstn,
  input  wire logic                       i_valid,
  output logic                            o_ready,
  input  wire logic [W-1:0]               i_data,
  output logic                            o_valid,
  input  wire logic                       i_ready,
  output logic [W-1:0]                    o_data,
  output logic [$clog2(DEPTH):0]          o_level
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [PW:0]  wp_q, wp_d, rp_q, rp_d;
  logic         push, pop;

  // pointers carry one extra bit so full and empty differ honestly
  assign o_level = wp_q - rp_q;
  assign o_ready = o_level != (PW+1)'(DEPTH);
  assign o_valid = wp_q != rp_q;
  assign o_data  = mem_q[rp_q[PW-1:0]];
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  always_comb begin
    wp_d = wp_q + (PW+1)'(push);
    rp_d = rp_q + (PW+1)'(pop);
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  // storage needs no reset; only written words are ever read
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_q[wp_q[PW-1:0]] <= i_data;
    end
  end
endmodule

module mpc_ctl
  import mpc_pkg::*;
(
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rstn,
  mpc_afi_if.ctl                     afi,
  input  wire logic                  i_cmd_valid,
  input  wire logic                  i_cmd_write,
  input  wire logic [MEM_ADDR_W-1:0] i_cmd_addr,
  output logic                       o_cmd_ack,
  input  wire logic                  i_wdata_valid,
  output logic                       o_wdata_ready,
  input  wire logic [AFI_DQ_W-1:0]   i_wdata,
  output logic [AFI_DQ_W-1:0]        o_rdata,
  output logic                       o_rdata_valid,
  output logic                       o_ready
);
  typedef enum logic [2:0] {
    ST_CAL  = 3'b000,
    ST_IDLE = 3'b001,
    ST_WR   = 3'b010,
    ST_RD   = 3'b011,
    ST_GAP  = 3'b100
  } mpc_state_t;

  mpc_state_t              st_q, st_d;
  logic [WLAT_W-1:0]       cnt_q, cnt_d, wlat_q, wlat_d;
  logic                    ack_q, ack_d, rdy_q, rdy_d;
  logic [AFI_DQ_W-1:0]     rdata_q, rdata_d;
  logic                    rvalid_q, rvalid_d;
  logic [AFI_ADDR_W-1:0]   addr_q, addr_d;
  logic [1:0]              cs_q, cs_d, dqs_q, dqs_d, wv_q, wv_d, ren_q, ren_d;
  logic [2:0]              cmd0_q, cmd0_d, cmd1_q, cmd1_d;
  logic [AFI_DQ_W-1:0]     wdat_q, wdat_d;
  logic                    f_valid, f_pop;
  logic [AFI_DQ_W-1:0]     f_data;
  logic [$clog2(FIFO_DEPTH):0] f_level;

  // back-pressure: o_wdata_ready drops once eight words wait
  mpc_fifo #(.W(AFI_DQ_W), .DEPTH(FIFO_DEPTH)) u_wfifo (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_valid   (i_wdata_valid),
    .o_ready   (o_wdata_ready),
    .i_data    (i_wdata),
    .o_valid   (f_valid),
    .i_ready   (f_pop),
    .o_data    (f_data),
    .o_level   (f_level)
  );

  // command sequencer; state moves only on controller-cycle edges
  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    wlat_d   = wlat_q;
    ack_d    = 1'b0;
    rdy_d    = rdy_q;
    addr_d   = addr_q;
    cs_d     = cs_q;
    dqs_d    = dqs_q;
    wv_d     = wv_q;
    ren_d    = ren_q;
    cmd0_d   = cmd0_q;
    cmd1_d   = cmd1_q;
    wdat_d   = wdat_q;
    f_pop    = 1'b0;
    rdata_d  = rdata_q;
    rvalid_d = 1'b0;
    // capture only on the PHY's valid, never on a local latency count
    if (afi.afi_tick && afi.rdata_valid) begin
      rdata_d  = afi.rdata;
      rvalid_d = 1'b1;
    end
    if (afi.afi_tick) begin
      cs_d   = CS_IDLE;
      dqs_d  = SLICE_NONE;
      wv_d   = SLICE_NONE;
      ren_d  = SLICE_NONE;
      cmd0_d = MPC_CMD_NOP;
      cmd1_d = MPC_CMD_NOP;
      case (st_q)
        ST_CAL: begin
          if (afi.cal_success) begin
            wlat_d = afi.wlat;
            rdy_d  = 1'b1;
            st_d   = ST_IDLE;
          end
        end
        ST_IDLE: begin
          // a write waits until its whole burst sits in the FIFO
          if (i_cmd_valid && i_cmd_write && f_level >= BURST_WORDS) begin
            addr_d = {i_cmd_addr, i_cmd_addr};
            cs_d   = SLICE_HI;            // select on slice 0 only
            cmd0_d = MPC_CMD_WR;
            cnt_d  = WLAT_W'(1);
            ack_d  = 1'b1;
            st_d   = ST_WR;
          end else if (i_cmd_valid && !i_cmd_write) begin
            addr_d = {i_cmd_addr, i_cmd_addr};
            ren_d  = SLICE_ALL;
            cs_d   = SLICE_LO;            // select on slice 1, one beat later
            cmd1_d = MPC_CMD_RD;
            ack_d  = 1'b1;
            st_d   = ST_RD;
          end
        end
        ST_WR: begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == wlat_q - 1'b1) begin
            dqs_d = SLICE_HI;
          end
          if (cnt_q >= wlat_q) begin
            dqs_d  = SLICE_ALL;
            wv_d   = SLICE_ALL;
            wdat_d = f_data;
            f_pop  = 1'b1;
            if (cnt_q == wlat_q + 1'b1) begin
              st_d = ST_GAP;
            end
          end
        end
        ST_RD: begin
          ren_d = SLICE_ALL;
          st_d  = ST_GAP;
        end
        ST_GAP: begin
          st_d = ST_IDLE;
        end
        default: begin
          st_d = ST_CAL;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q     <= ST_CAL;
      cnt_q    <= '0;
      wlat_q   <= WLAT_RST;
      ack_q    <= 1'b0;
      rdy_q    <= 1'b0;
      addr_q   <= '0;
      cs_q     <= CS_IDLE;
      dqs_q    <= SLICE_NONE;
      wv_q     <= SLICE_NONE;
      ren_q    <= SLICE_NONE;
      cmd0_q   <= MPC_CMD_NOP;
      cmd1_q   <= MPC_CMD_NOP;
      wdat_q   <= '0;
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      wlat_q   <= wlat_d;
      ack_q    <= ack_d;
      rdy_q    <= rdy_d;
      addr_q   <= addr_d;
      cs_q     <= cs_d;
      dqs_q    <= dqs_d;
      wv_q     <= wv_d;
      ren_q    <= ren_d;
      cmd0_q   <= cmd0_d;
      cmd1_q   <= cmd1_d;
      wdat_q   <= wdat_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // link words are twice the memory width, low half first
  assign afi.addr        = addr_q;
  assign afi.cs_n        = cs_q;
  assign afi.ras_n       = {cmd1_q[2], cmd0_q[2]};
  assign afi.cas_n       = {cmd1_q[1], cmd0_q[1]};
  assign afi.we_n        = {cmd1_q[0], cmd0_q[0]};
  assign afi.dqs_burst   = dqs_q;
  assign afi.wdata_valid = wv_q;
  assign afi.wdata       = wdat_q;
  assign afi.rdata_en    = ren_q;
  assign o_cmd_ack       = ack_q;
  assign o_rdata         = rdata_q;
  assign o_rdata_valid   = rvalid_q;
  assign o_ready         = rdy_q;
endmodule
`default_nettype wire

// ===== design/mpc_pkg.sv
// Purpose: shared constants and types for the controller-to-PHY link
// Assumes: i_ref_clk is the 125 MHz memory clock; controller cycle is two of them
// Notes:   half-rate only, burst of four, 16-bit memory data, one beat per memory clock
package mpc_pkg;
  localparam int CLK_NS       = 8;                      // 125 MHz reference
  localparam int RATIO        = 2;                      // interface over memory width
  localparam int MEM_DQ_W     = 16;                     // two bytes per memory clock
  localparam int AFI_DQ_W     = RATIO * MEM_DQ_W;       // 32-bit interface word
  localparam int MEM_ADDR_W   = 10;
  localparam int AFI_ADDR_W   = RATIO * MEM_ADDR_W;
  localparam int WLAT_W       = 4;
  localparam int RLAT         = 15;                     // controller cycles
  localparam int CAL_TIME_NS  = 256;                    // calibration run time
  localparam int CAL_CYCLES   = (CAL_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int CAL_CNT_W    = 8;
  localparam int FIFO_DEPTH   = 8;
  localparam int BURST_WORDS  = 2;                      // four beats at half rate
  localparam int SYNC_STAGES  = 3;
  localparam logic [WLAT_W-1:0] WLAT_VAL   = 4'h2;      // reported after calibration
  localparam logic [WLAT_W-1:0] WLAT_RST   = 4'h0;
  localparam logic [1:0]        SLICE_ALL  = 2'h3;
  localparam logic [1:0]        SLICE_LO   = 2'h1;
  localparam logic [1:0]        SLICE_HI   = 2'h2;
  localparam logic [1:0]        SLICE_NONE = 2'h0;
  localparam logic [1:0]        CS_IDLE    = 2'h3;      // active low, both slices off

  // row strobe, column strobe, write enable (all active low)
  typedef enum logic [2:0] {
    MPC_CMD_NOP = 3'b111,
    MPC_CMD_WR  = 3'b100,
    MPC_CMD_RD  = 3'b101
  } mpc_cmd_t;

  // one memory-clock beat as it leaves the PHY
  typedef struct packed {
    logic                  cs_n;
    logic [2:0]            cmd;
    logic [MEM_ADDR_W-1:0] addr;
    logic [MEM_DQ_W-1:0]   dq;
    logic                  dq_oe;
    logic                  dqs_en;
  } mpc_beat_t;
endpackage

// ===== design/mpc_afi_if.sv
// Purpose: controller-to-PHY link, one modport per party
// Assumes: controller-driven signals change only on a controller-cycle boundary
// Notes:   two-bit fields carry slice 0 (sent first) and slice 1
`timescale 1ns/1ns
`default_nettype none
interface mpc_afi_if;
  import mpc_pkg::*;
  logic                    afi_tick;     // phase of the controller cycle
  logic                    cal_success;
  logic [WLAT_W-1:0]       wlat;
  logic [AFI_ADDR_W-1:0]   addr;
  logic [1:0]              cs_n;
  logic [1:0]              ras_n;
  logic [1:0]              cas_n;
  logic [1:0]              we_n;
  logic [1:0]              dqs_burst;
  logic [1:0]              wdata_valid;
  logic [AFI_DQ_W-1:0]     wdata;
  logic [1:0]              rdata_en;
  logic [AFI_DQ_W-1:0]     rdata;
  logic                    rdata_valid;

  modport phy (
    output afi_tick, cal_success, wlat, rdata, rdata_valid,
    input  addr, cs_n, ras_n, cas_n, we_n, dqs_burst, wdata_valid, wdata, rdata_en
  );
  modport ctl (
    input  afi_tick, cal_success, wlat, rdata, rdata_valid,
    output addr, cs_n, ras_n, cas_n, we_n, dqs_burst, wdata_valid, wdata, rdata_en
  );
endinterface
`default_nettype wire

// ===== design/mpc_phy.sv
// Purpose: PHY end, serialises interface words onto the memory pins
// Assumes: controller obeys write latency, strobe lead and read-enable timing
// Notes:   read data pins pass a 3-stage filter before word assembly
`timescale 1ns/1ns
`default_nettype none
module mpc_phy
  import mpc_pkg::*;
(
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rstn,
  mpc_afi_if.phy                     afi,
  output logic                       o_mem_cs_n,
  output logic                       o_mem_ras_n,
  output logic                       o_mem_cas_n,
  output logic                       o_mem_we_n,
  output logic [MEM_ADDR_W-1:0]      o_mem_addr,
  output logic [MEM_DQ_W-1:0]        o_mem_dq,
  output logic                       o_mem_dq_oe,
  output logic                       o_mem_dqs_en,
  input  wire logic [MEM_DQ_W-1:0]   i_mem_rdq
);
  localparam mpc_beat_t BEAT_IDLE = '{cs_n: 1'b1, cmd: MPC_CMD_NOP, default: '0};

  logic                  tick_q, tick_d;
  logic [CAL_CNT_W-1:0]  cal_cnt_q, cal_cnt_d;
  logic                  cal_q, cal_d;
  logic [WLAT_W-1:0]     wlat_q, wlat_d;
  logic [RLAT-1:0]       en_pipe_q, en_pipe_d;
  logic                  rvalid_q, rvalid_d;
  logic [MEM_DQ_W-1:0]   lo_q, lo_d;
  logic [AFI_DQ_W-1:0]   rdata_q, rdata_d;
  mpc_beat_t             out_q, out_d, hold_q, hold_d, slice0, slice1;
  logic [MEM_DQ_W-1:0]   s1_q, s2_q, s3_q, filt_q;
  logic                  load;

  // tick high: controller updates; tick low: interface is stable and sampled
  assign load = ~tick_q;

  // per-bit synchroniser; a bit moves only once stages two and three agree
  for (genvar b = 0; b < MEM_DQ_W; b++) begin : g_sync
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        s1_q[b]   <= 1'b0;
        s2_q[b]   <= 1'b0;
        s3_q[b]   <= 1'b0;
        filt_q[b] <= 1'b0;
      end else begin
        s1_q[b] <= i_mem_rdq[b];
        s2_q[b] <= s1_q[b];
        s3_q[b] <= s2_q[b];
        if (s2_q[b] == s3_q[b]) begin
          filt_q[b] <= s3_q[b];
        end
      end
    end
  end

  // slice 0 of every field goes out first, slice 1 one memory clock later
  always_comb begin
    slice0 = '{cs_n: afi.cs_n[0],
               cmd: {afi.ras_n[0], afi.cas_n[0], afi.we_n[0]},
               addr: afi.addr[MEM_ADDR_W-1:0],
               dq: afi.wdata[MEM_DQ_W-1:0],
               dq_oe: afi.wdata_valid[0],
               dqs_en: afi.dqs_burst[0]};
    slice1 = '{cs_n: afi.cs_n[1],
               cmd: {afi.ras_n[1], afi.cas_n[1], afi.we_n[1]},
               addr: afi.addr[AFI_ADDR_W-1:MEM_ADDR_W],
               dq: afi.wdata[AFI_DQ_W-1:MEM_DQ_W],
               dq_oe: afi.wdata_valid[1],
               dqs_en: afi.dqs_burst[1]};
  end

  // next-state for tick, calibration, beat output and read return
  always_comb begin
    tick_d    = ~tick_q;
    cal_cnt_d = cal_cnt_q;
    cal_d     = cal_q;
    wlat_d    = wlat_q;
    out_d     = out_q;
    hold_d    = hold_q;
    en_pipe_d = en_pipe_q;
    rvalid_d  = rvalid_q;
    lo_d      = lo_q;
    rdata_d   = rdata_q;
    if (!cal_q) begin
      if (cal_cnt_q == CAL_CNT_W'(CAL_CYCLES - 1)) begin
        cal_d  = 1'b1;
        wlat_d = WLAT_VAL;
      end else begin
        cal_cnt_d = cal_cnt_q + 1'b1;
      end
    end
    if (load) begin
      // stateless per word, so back-to-back and spaced commands both pass
      out_d     = slice0;
      hold_d    = slice1;
      en_pipe_d = {en_pipe_q[RLAT-2:0], |afi.rdata_en};
      rvalid_d  = en_pipe_q[RLAT-1];
      rdata_d   = {filt_q, lo_q};
    end else begin
      out_d = hold_q;
      lo_d  = filt_q;                       // first beat is the low half
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_q    <= 1'b0;
      cal_cnt_q <= '0;
      cal_q     <= 1'b0;
      wlat_q    <= WLAT_RST;
      out_q     <= BEAT_IDLE;
      hold_q    <= BEAT_IDLE;
      en_pipe_q <= '0;
      rvalid_q  <= 1'b0;
      lo_q      <= '0;
      rdata_q   <= '0;
    end else begin
      tick_q    <= tick_d;
      cal_cnt_q <= cal_cnt_d;
      cal_q     <= cal_d;
      wlat_q    <= wlat_d;
      out_q     <= out_d;
      hold_q    <= hold_d;
      en_pipe_q <= en_pipe_d;
      rvalid_q  <= rvalid_d;
      lo_q      <= lo_d;
      rdata_q   <= rdata_d;
    end
  end

  // whole-word outputs; every bit of a word is valid in the same cycle
  assign afi.afi_tick    = tick_q;
  assign afi.cal_success = cal_q;
  assign afi.wlat        = wlat_q;
  assign afi.rdata       = rdata_q;
  assign afi.rdata_valid = rvalid_q;
  assign o_mem_cs_n      = out_q.cs_n;
  assign o_mem_ras_n     = out_q.cmd[2];
  assign o_mem_cas_n     = out_q.cmd[1];
  assign o_mem_we_n      = out_q.cmd[0];
  assign o_mem_addr      = out_q.addr;
  assign o_mem_dq        = out_q.dq;
  assign o_mem_dq_oe     = out_q.dq_oe;
  assign o_mem_dqs_en    = out_q.dqs_en;
endmodule
`default_nettype wire

// ===== tb/mpc_afi_monitor.sv
// Purpose: protocol checks on the controller-to-PHY link
// Assumes: PHY samples the link on edges where afi_tick is low
// Notes:   write latency 2 and read latency 15 controller cycles, as reported
`timescale 1ns/1ns
`default_nettype none
module mpc_afi_monitor
  import mpc_pkg::*;
(
  input wire logic                  i_ref_clk,
  input wire logic                  i_rstn,
  input wire logic                  afi_tick,
  input wire logic                  cal_success,
  input wire logic [WLAT_W-1:0]     wlat,
  input wire logic [AFI_ADDR_W-1:0] addr,
  input wire logic [1:0]            cs_n,
  input wire logic [1:0]            ras_n,
  input wire logic [1:0]            cas_n,
  input wire logic [1:0]            we_n,
  input wire logic [1:0]            dqs_burst,
  input wire logic [1:0]            wdata_valid,
  input wire logic [1:0]            rdata_en,
  input wire logic                  rdata_valid
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  // commands as the PHY samples them, once per controller cycle
  sequence wr_sel;
    cs_n == 2'h2 && !afi_tick;
  endsequence
  sequence rd_sel;
    cs_n == 2'h1 && !afi_tick;
  endsequence
  sequence any_sel;
    cs_n != CS_IDLE && !afi_tick;
  endsequence

  wlat_report_a: assert property (wlat == (cal_success ? WLAT_VAL : WLAT_RST))
    else $error("write latency does not follow calibration");
  tick_cycle_a: assert property (afi_tick |=> !afi_tick ##1 afi_tick)
    else $error("controller cycle is not two clocks");
  wr_code_a: assert property (wr_sel |-> {ras_n[0], cas_n[0], we_n[0]} == MPC_CMD_WR)
    else $error("write select without write command");
  rd_code_a: assert property (rd_sel |-> {ras_n[1], cas_n[1], we_n[1]} == MPC_CMD_RD)
    else $error("read select without read command");
  addr_dup_a: assert property (any_sel |-> addr[9:0] == addr[19:10])
    else $error("address slices differ");
  strobe_lead_a: assert property ($rose(wdata_valid[0]) |->
    $past(dqs_burst) == SLICE_HI && dqs_burst == SLICE_ALL)
    else $error("strobe burst does not lead write valid by one beat");
  write_latency_a: assert property (wr_sel |-> (wdata_valid == SLICE_NONE) [*4]
    ##1 (wdata_valid == SLICE_ALL) [*4] ##1 (wdata_valid == SLICE_NONE))
    else $error("write valid not two cycles after select");
  rd_enable_a: assert property (rd_sel |-> (rdata_en == SLICE_ALL) [*4]
    ##1 (rdata_en == SLICE_NONE))
    else $error("read enable not both slices for the burst");
  rd_latency_a: assert property (rd_sel |-> ##31 rdata_valid [*4] ##1 !rdata_valid)
    else $error("read valid not fifteen cycles after read enable");
  cmd_spacing_a: assert property (any_sel |-> ##2 (cs_n == CS_IDLE) [*4])
    else $error("no idle cycle after a command");
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: runs writes and reads through both link ends via the user port
// Assumes: 125 MHz clock; memory read pins change level once per read
// Notes:   read pins step once mid-burst so word halves show their order
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp=%h got=%h", nm, e, g); end end
module testbench
  import mpc_pkg::*;
;
  logic                    i_ref_clk;
  logic                    i_rstn;
  logic                    i_cmd_valid;
  logic                    i_cmd_write;
  logic [MEM_ADDR_W-1:0]   i_cmd_addr;
  logic                    i_wdata_valid;
  logic [AFI_DQ_W-1:0]     i_wdata;
  logic [MEM_DQ_W-1:0]     i_mem_rdq;
  logic                    o_cmd_ack;
  logic                    o_wdata_ready;
  logic                    o_rdata_valid;
  logic                    o_ready;
  logic [AFI_DQ_W-1:0]     o_rdata;
  logic                    mem_cs_n;
  logic                    mem_ras_n;
  logic                    mem_cas_n;
  logic                    mem_we_n;
  logic [MEM_ADDR_W-1:0]   mem_addr;
  logic [MEM_DQ_W-1:0]     mem_dq;
  logic                    mem_dq_oe;
  logic                    mem_dqs_en;
  logic [MEM_DQ_W-1:0]     dq_q[$];
  logic [MEM_ADDR_W+2:0]   cmd_q[$];
  logic [AFI_DQ_W-1:0]     rd_q[$];
  int                      error_cnt;
  int                      n_tests;
  int                      dqs_beats;

  // free-running memory clock
  initial begin
    i_ref_clk = 1'b0;
    forever #(CLK_NS/2) i_ref_clk = ~i_ref_clk;
  end

  mpc_afi_if i_mpc_afi_if ();
  mpc_phy i_mpc_phy (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .afi(i_mpc_afi_if),
    .o_mem_cs_n(mem_cs_n), .o_mem_ras_n(mem_ras_n), .o_mem_cas_n(mem_cas_n),
    .o_mem_we_n(mem_we_n), .o_mem_addr(mem_addr), .o_mem_dq(mem_dq),
    .o_mem_dq_oe(mem_dq_oe), .o_mem_dqs_en(mem_dqs_en), .i_mem_rdq(i_mem_rdq));
  mpc_ctl i_mpc_ctl (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .afi(i_mpc_afi_if),
    .i_cmd_valid(i_cmd_valid), .i_cmd_write(i_cmd_write), .i_cmd_addr(i_cmd_addr),
    .o_cmd_ack(o_cmd_ack), .i_wdata_valid(i_wdata_valid), .o_wdata_ready(o_wdata_ready),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid), .o_ready(o_ready));
  mpc_afi_monitor i_mpc_afi_monitor (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
    .afi_tick(i_mpc_afi_if.afi_tick), .cal_success(i_mpc_afi_if.cal_success),
    .wlat(i_mpc_afi_if.wlat), .addr(i_mpc_afi_if.addr), .cs_n(i_mpc_afi_if.cs_n),
    .ras_n(i_mpc_afi_if.ras_n), .cas_n(i_mpc_afi_if.cas_n), .we_n(i_mpc_afi_if.we_n),
    .dqs_burst(i_mpc_afi_if.dqs_burst), .wdata_valid(i_mpc_afi_if.wdata_valid),
    .rdata_en(i_mpc_afi_if.rdata_en), .rdata_valid(i_mpc_afi_if.rdata_valid));

  // pins are registered, so the falling edge sees each beat settled
  always @(negedge i_ref_clk) begin
    if (i_rstn && mem_dq_oe) dq_q.push_back(mem_dq);
    if (i_rstn && mem_dqs_en) dqs_beats++;
    if (i_rstn && !mem_cs_n) cmd_q.push_back({mem_ras_n, mem_cas_n, mem_we_n, mem_addr});
    if (o_rdata_valid === 1'b1) rd_q.push_back(o_rdata);
  end

  // holds valid up so back-to-back pushes never re-drive it in one step
  task automatic push(input logic [AFI_DQ_W-1:0] w);
    i_wdata       <= w;
    i_wdata_valid <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(negedge i_ref_clk);
      if (o_wdata_ready === 1'b1) break;
    end
    @(posedge i_ref_clk);
  endtask

  // one command, held until acknowledged
  task automatic issue(input logic wr, input logic [MEM_ADDR_W-1:0] a);
    @(posedge i_ref_clk);
    i_cmd_valid <= 1'b1;
    i_cmd_write <= wr;
    i_cmd_addr  <= a;
    for (int k = 0; k < 100; k++) begin
      @(negedge i_ref_clk);
      if (o_cmd_ack === 1'b1) break;
    end
    `CHK("cmd_ack", 1'b1, o_cmd_ack)
    @(posedge i_ref_clk);
    i_cmd_valid <= 1'b0;
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // whole run is under a thousand clocks; this cuts a hang short
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    error_cnt++;
    $display("CHECK FAILED watchdog exp=finished got=hung");
    summarize();
  end

  // main sequence
  initial begin
    logic [AFI_DQ_W-1:0]   wd [8];
    logic [MEM_ADDR_W-1:0] ad [4];
    logic [MEM_DQ_W-1:0]   v;
    logic [MEM_DQ_W-1:0]   b;
    logic [MEM_ADDR_W+2:0] c;
    logic [AFI_DQ_W-1:0]   w;
    error_cnt = 0;
    n_tests = 0;
    i_rstn = 1'b0;
    i_cmd_valid = 1'b0;
    i_cmd_write = 1'b0;
    i_cmd_addr = '0;
    i_wdata_valid = 1'b0;
    i_wdata = '0;
    i_mem_rdq = 16'hFFFF;
    ad = '{10'h000, 10'h3FF, 10'h155, 10'h2AA};
    repeat (4) @(posedge i_ref_clk);
    `CHK("reset_cs", 1'b1, mem_cs_n)
    `CHK("reset_oe", 1'b0, mem_dq_oe)
    i_rstn <= 1'b1;
    // a command offered during calibration is ignored
    i_cmd_valid <= 1'b1;
    for (int k = 0; k < 20; k++) begin
      @(negedge i_ref_clk);
      `CHK("early_ack", 1'b0, o_cmd_ack)
    end
    @(posedge i_ref_clk);
    i_cmd_valid <= 1'b0;
    for (int k = 0; k < 60 && o_ready !== 1'b1; k++) @(posedge i_ref_clk);
    `CHK("ready", 1'b1, o_ready)
    `CHK("wlat", WLAT_VAL, i_mpc_afi_if.wlat)
    `CHK("width_ratio", 2 * $bits(mem_dq), $bits(i_mpc_afi_if.wdata))
    $display("test calibration done");
    // fill the buffer until it refuses, then drain it with four writes
    for (int i = 0; i < 8; i++) begin
      wd[i] = 32'h0F1E2D3C + 32'(i) * 32'h11111111;
      push(wd[i]);
    end
    i_wdata_valid <= 1'b0;
    @(negedge i_ref_clk);
    `CHK("fifo_full", 1'b0, o_wdata_ready)
    for (int i = 0; i < 4; i++) issue(1'b1, ad[i]);
    for (int k = 0; k < 100 && dq_q.size() < 16; k++) @(posedge i_ref_clk);
    `CHK("wr_beats", 16, dq_q.size())
    `CHK("wr_cmds", 4, cmd_q.size())
    // strobe runs one lead beat plus every data beat of each burst
    `CHK("dqs_beats", 4 * (2 * BURST_WORDS + 1), dqs_beats)
    for (int i = 0; i < 4; i++) begin
      c = cmd_q.pop_front();
      `CHK("wr_cmd", {MPC_CMD_WR, ad[i]}, c)
      for (int j = 0; j < 4; j++) begin
        b = dq_q.pop_front();
        `CHK("wr_beat", wd[2*i + j/2][16*(j%2) +: 16], b)
      end
    end
    `CHK("fifo_empty", 1'b1, o_wdata_ready)
    $display("test writes done");
    // reads: pins step from v to ~v so the first word splits between halves
    for (int i = 0; i < 3; i++) begin
      v = {8'hA0 + 8'(i), 8'h5F};
      i_mem_rdq <= v;
      issue(1'b0, ad[i+1]);
      // four-clock pin filter lands the step between first-word beats
      repeat (2 * RLAT - 5) @(posedge i_ref_clk);
      i_mem_rdq <= ~v;
      for (int k = 0; k < 100 && rd_q.size() < 2; k++) @(posedge i_ref_clk);
      c = cmd_q.pop_front();
      `CHK("rd_cmd", {MPC_CMD_RD, ad[i+1]}, c)
      `CHK("rd_words", 2, rd_q.size())
      for (int k = 0; k < 2; k++) begin
        w = rd_q.pop_front();
        `CHK("rd_data", (k == 0) ? {~v, v} : {~v, ~v}, w)
      end
      @(posedge i_ref_clk);
    end
    $display("test reads done");
    summarize();
  end
endmodule
`default_nettype wire
